// ---- logic/mal_core.sv ----
// instruction decode and execution timing sequencer of the mcu core
`timescale 1ns/1ps
module mal_core (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [7:0]  code_byte,
    input  wire logic [1:0]  bank_sel,
    input  wire logic [15:0] data_pointer_pair,
    input  wire logic [7:0]  xdm_page,
    input  wire logic        flash_access_en,
    input  wire logic        breg_we,
    input  wire logic [4:0]  breg_waddr,
    input  wire logic [7:0]  breg_wdata,
    output logic      [15:0] code_addr,
    output logic             instr_done,
    output mal_pkg::mal_dec_s instr,
    output mal_pkg::mal_xdm_s xdm
);
    import mal_pkg::*;

    logic [1:0] rst_q;
    logic       rst_n;
    mal_state_e st;
    logic [1:0] left;
    logic [1:0] idx;
    logic [7:0] cur;
    mal_op_s    cur_op;
    logic [1:0] bank;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [2:0] gap;
    logic [7:0] breg_rdata;

    // opcode classification into class and operand mode
    function automatic mal_op_s op_decode(input logic [7:0] op);
        mal_op_s r;
        logic [3:0] hi;
        logic [3:0] lo;
        logic breg_form;
        logic ptr_form;
        logic g_ar;
        logic g_lg;
        r = '{CL_UNSUP, MD_NONE};
        hi = op[7:4];
        lo = op[3:0];
        breg_form = op[3];
        ptr_form = lo[3:1] == LO_IND;
        g_ar = hi == HI_ADD || hi == HI_ADDC || hi == HI_SUBB;
        g_lg = hi == HI_ORL || hi == HI_ANL || hi == HI_XRL;
        if (op == OP_NOP || op == OP_NOP_ALT) begin
            r = '{CL_NOP, MD_NONE};
        end else if (op == OP_RR || op == OP_RRC || op == OP_RL || op == OP_RLC || op == OP_SWAP ||
                     op == OP_CLR_A || op == OP_CPL_A) begin
            r = '{CL_ACC, MD_ACC};
        end else if (g_ar || g_lg) begin
            r.cls = g_ar ? CL_ARITH : CL_LOGIC;
            if (breg_form) r.mode = MD_REG;
            else if (ptr_form) r.mode = MD_IND;
            else if (lo == LO_A_DIR) r.mode = MD_DIR;
            else if (lo == LO_A_IMM) r.mode = MD_IMM;
            else if (g_lg && lo == LO_DIR_A) r.mode = MD_DIR_A;
            else if (g_lg && lo == LO_DIR_IMM) r.mode = MD_DIR_IMM;
            else r.cls = CL_UNSUP;
        end else if ((hi == HI_MOV_A || hi == HI_MOV_R) && (lo == LO_XDM_DP || lo[3:1] == LO_XRI)) begin
            r = '{CL_XDM, MD_XDM};
        end else begin
            r.cls = CL_MOVE;
            if (op == OP_MOV_A_DIR) r.mode = MD_DIR;
            else if (op == OP_MOV_A_IMM) r.mode = MD_IMM;
            else if (op == OP_MOV_DIR_A) r.mode = MD_DIR_A;
            else if (op == OP_MOV_DIR_DIR) r.mode = MD_DIR_DIR;
            else if ((hi == HI_MOV_A || hi == HI_MOV_R) && breg_form) r.mode = MD_REG;
            else if (hi == HI_MOV_A && ptr_form) r.mode = MD_IND;
            else if (hi == HI_BR_IMM && breg_form) r.mode = MD_IMM;
            else if (hi == HI_BR_DIR && breg_form) r.mode = MD_REG_DIR;
            else if (hi == HI_DIR_BR && breg_form) r.mode = MD_DIR_REG;
            else if (hi == HI_DIR_BR && ptr_form) r.mode = MD_DIR_IND;
            else r.cls = CL_UNSUP;
        end
        return r;
    endfunction

    // reset release through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // decode and timing selection
    wire mal_op_s   dc      = op_decode(code_byte);
    wire mal_time_s dt      = mode_time(dc.mode);
    wire mal_time_s ct      = mode_time(cur_op.mode);
    wire            in_opc  = st == ST_OPC;
    wire            take    = !in_opc && idx < ct.len;
    wire            retire  = in_opc ? dt.cyc == N_ONE : left == N_ONE;
    wire [7:0]      r_op    = in_opc ? code_byte : cur;
    wire mal_op_s   r_cls   = in_opc ? dc : cur_op;
    wire mal_time_s r_time  = in_opc ? dt : ct;
    wire [1:0]      r_bank  = in_opc ? bank_sel : bank;
    wire [7:0]      next_op1 = (take && idx == N_ONE) ? code_byte : op1;
    wire [7:0]      next_op2 = (take && idx == N_TWO) ? code_byte : op2;
    wire [4:0]      r_reg   = r_op[3] ? {r_bank, r_op[2:0]} : {r_bank, PTR_PAD, r_op[0]};
    wire [4:0]      ptr_raddr = {bank_sel, PTR_PAD, code_byte[0]};

    wire mal_state_e next_st   = retire ? ST_OPC : ST_BODY;
    wire [1:0]       next_left = in_opc ? dt.cyc - N_ONE : left - N_ONE;
    wire [1:0]       next_idx  = in_opc ? N_ONE : (take ? idx + N_ONE : idx);
    wire [15:0]      next_pc   = (in_opc || take) ? code_addr + PC_STEP : code_addr;

    // external data move target selection
    wire [15:0]   xa       = cur[1] ? {xdm_page, breg_rdata} : data_pointer_pair;
    wire          x_write  = cur[7:4] == HI_MOV_R;
    wire mal_tgt_e x_tgt   = flash_access_en ? TG_FLASH :
                             (xa < EXP_ONCHIP_TOP ? TG_ONCHIP : TG_OFFCHIP);
    wire mal_xdm_s next_xdm = '{retire && r_cls.cls == CL_XDM, x_write, x_tgt, xa};

    wire mal_dec_s rec = '{
        opcode:   r_op,
        cls:      r_cls.cls,
        mode:     r_cls.mode,
        len:      r_time.len,
        cyc:      r_time.cyc,
        op1:      next_op1,
        op2:      next_op2,
        op1_special: next_op1 >= SPECIAL_BASE,
        op2_special: next_op2 >= SPECIAL_BASE,
        reg_addr: r_reg,
        ind_addr: breg_rdata
    };

    mal_breg_mem u_breg (
        .clock (clock),
        .rst_n (rst_n),
        .we    (breg_we),
        .waddr (breg_waddr),
        .wdata (breg_wdata),
        .re    (in_opc),
        .raddr (ptr_raddr),
        .rdata (breg_rdata)
    );

    // sequencer, one opcode fetch then body cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st        <= ST_OPC;
            left      <= N_ONE;
            idx       <= N_ONE;
            code_addr <= PC_RESET;
        end else begin
            st        <= next_st;
            left      <= next_left;
            idx       <= next_idx;
            code_addr <= next_pc;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur    <= OP_NOP;
            cur_op <= '{CL_NOP, MD_NONE};
            bank   <= PTR_PAD;
            op1    <= 8'h00;
            op2    <= 8'h00;
        end else begin
            if (in_opc) begin
                cur    <= code_byte;
                cur_op <= dc;
                bank   <= bank_sel;
            end
            op1 <= next_op1;
            op2 <= next_op2;
        end
    end

    // retired instruction record
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            instr_done <= 1'b0;
            instr      <= '0;
            xdm        <= '0;
        end else begin
            instr_done <= retire;
            if (retire) begin
                instr <= rec;
                xdm   <= next_xdm;
            end else begin
                xdm.valid <= 1'b0;
            end
        end
    end

    // cycles since previous retirement
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 3'h0;
        end else if (instr_done) begin
            gap <= GAP_ONE;
        end else if (gap != GAP_MAX) begin
            gap <= gap + GAP_ONE;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    wire ar = instr_done && instr.cls == CL_ARITH;
    wire lg = instr_done && instr.cls == CL_LOGIC;
    wire mv = instr_done && instr.cls == CL_MOVE;

    property p_xdm_target;
        xdm.valid && !$past(flash_access_en) |-> (xdm.target == TG_ONCHIP) == (xdm.addr < EXP_ONCHIP_TOP)
            && instr.cls == CL_XDM && gap == {1'b0, N_THREE};
    endproperty
    a_xdm_target: assert property (p_xdm_target) else $error("xdm target wrong");
    property p_xdm_flash;
        instr_done && instr.cls == CL_XDM && $past(flash_access_en) |-> xdm.valid && xdm.target == TG_FLASH;
    endproperty
    a_xdm_flash: assert property (p_xdm_flash) else $error("flash target missed");
    property p_ar_reg;
        ar && instr.mode == MD_REG |-> instr.len == N_ONE && gap == {1'b0, N_ONE};
    endproperty
    a_ar_reg: assert property (p_ar_reg) else $error("arith reg timing");
    property p_ar_dir;
        ar && instr.mode == MD_DIR |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_ar_dir: assert property (p_ar_dir) else $error("arith direct timing");
    property p_ar_ind;
        ar && instr.mode == MD_IND |-> instr.len == N_ONE && gap == {1'b0, N_TWO};
    endproperty
    a_ar_ind: assert property (p_ar_ind) else $error("arith indirect timing");
    property p_ar_imm;
        ar && instr.mode == MD_IMM |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_ar_imm: assert property (p_ar_imm) else $error("arith immediate timing");
    property p_lg_reg;
        lg && instr.mode == MD_REG |-> instr.len == N_ONE && gap == {1'b0, N_ONE};
    endproperty
    a_lg_reg: assert property (p_lg_reg) else $error("logic reg timing");
    property p_lg_dir;
        lg && instr.mode == MD_DIR |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_lg_dir: assert property (p_lg_dir) else $error("logic direct timing");
    property p_lg_ind;
        lg && instr.mode == MD_IND |-> instr.len == N_ONE && gap == {1'b0, N_TWO};
    endproperty
    a_lg_ind: assert property (p_lg_ind) else $error("logic indirect timing");
    property p_lg_imm;
        lg && instr.mode == MD_IMM |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_lg_imm: assert property (p_lg_imm) else $error("logic immediate timing");
    property p_lg_dir_a;
        lg && instr.mode == MD_DIR_A |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_lg_dir_a: assert property (p_lg_dir_a) else $error("logic to direct timing");
    property p_lg_dir_imm;
        lg && instr.mode == MD_DIR_IMM |-> instr.len == N_THREE && gap == {1'b0, N_THREE};
    endproperty
    a_lg_dir_imm: assert property (p_lg_dir_imm) else $error("logic imm to direct timing");
    property p_acc;
        instr_done && instr.cls == CL_ACC |-> instr.len == N_ONE && gap == {1'b0, N_ONE} && $past(in_opc);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator op timing");
    property p_mv_a_dir;
        mv && instr.mode == MD_DIR |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_mv_a_dir: assert property (p_mv_a_dir) else $error("load acc direct timing");
    property p_mv_a_ind;
        mv && instr.mode == MD_IND |-> instr.len == N_ONE && gap == {1'b0, N_TWO};
    endproperty
    a_mv_a_ind: assert property (p_mv_a_ind) else $error("load acc indirect timing");
    property p_mv_imm;
        mv && instr.mode == MD_IMM |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_mv_imm: assert property (p_mv_imm) else $error("load immediate timing");
    property p_mv_r_dir;
        mv && instr.mode == MD_REG_DIR |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_mv_r_dir: assert property (p_mv_r_dir) else $error("load reg direct timing");
    property p_mv_dir_dir;
        mv && instr.mode == MD_DIR_DIR |-> instr.len == N_THREE && gap == {1'b0, N_THREE};
    endproperty
    a_mv_dir_dir: assert property (p_mv_dir_dir) else $error("direct copy timing");
    property p_mv_dir_r;
        mv && instr.mode == MD_DIR_REG |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_mv_dir_r: assert property (p_mv_dir_r) else $error("store reg timing");
    property p_mv_dir_ind;
        mv && instr.mode == MD_DIR_IND |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_mv_dir_ind: assert property (p_mv_dir_ind) else $error("indirect to direct timing");
    property p_mv_dir_a;
        mv && instr.mode == MD_DIR_A |-> instr.len == N_TWO && gap == {1'b0, N_TWO};
    endproperty
    a_mv_dir_a: assert property (p_mv_dir_a) else $error("store acc timing");
    property p_ptr;
        instr_done && (instr.mode == MD_IND || instr.mode == MD_DIR_IND) |->
            instr.reg_addr[2:1] == PTR_PAD && instr.reg_addr[0] == instr.opcode[0]
            && instr.ind_addr == $past(breg_rdata);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer register wrong");
    property p_sfr;
        instr_done |-> instr.op1_special == instr.op1[7] && instr.op2_special == instr.op2[7];
    endproperty
    a_sfr: assert property (p_sfr) else $error("direct space wrong");
    property p_gap;
        instr_done |-> gap == {1'b0, instr.cyc} ##1 $past(in_opc);
    endproperty
    a_gap: assert property (p_gap) else $error("gap between instructions");
endmodule

// ---- logic/mal_pkg.sv ----
// shared constants, types and timing table for the instruction sequencer
package mal_pkg;
    localparam logic [7:0]  SPECIAL_BASE    = 8'h80;
    localparam logic [15:0] EXP_ONCHIP_TOP  = 16'h1000;
    localparam logic [15:0] PC_RESET        = 16'h0000;
    localparam logic [15:0] PC_STEP         = 16'h0001;
    localparam logic [1:0]  PTR_PAD         = 2'h0;
    localparam logic [1:0]  N_ONE           = 2'h1;
    localparam logic [1:0]  N_TWO           = 2'h2;
    localparam logic [1:0]  N_THREE         = 2'h3;
    localparam logic [2:0]  GAP_ONE         = 3'h1;
    localparam logic [2:0]  GAP_MAX         = 3'h7;

    localparam logic [3:0] HI_ADD     = 4'h2;
    localparam logic [3:0] HI_ADDC    = 4'h3;
    localparam logic [3:0] HI_SUBB    = 4'h9;
    localparam logic [3:0] HI_ORL     = 4'h4;
    localparam logic [3:0] HI_ANL     = 4'h5;
    localparam logic [3:0] HI_XRL     = 4'h6;
    localparam logic [3:0] HI_MOV_A   = 4'hE;
    localparam logic [3:0] HI_MOV_R   = 4'hF;
    localparam logic [3:0] HI_BR_DIR  = 4'hA;
    localparam logic [3:0] HI_BR_IMM  = 4'h7;
    localparam logic [3:0] HI_DIR_BR  = 4'h8;
    localparam logic [3:0] LO_DIR_A   = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;
    localparam logic [3:0] LO_A_IMM   = 4'h4;
    localparam logic [3:0] LO_A_DIR   = 4'h5;
    localparam logic [3:0] LO_XDM_DP  = 4'h0;
    localparam logic [2:0] LO_IND     = 3'h3;
    localparam logic [2:0] LO_XRI     = 3'h1;

    localparam logic [7:0] OP_NOP         = 8'h00;
    localparam logic [7:0] OP_NOP_ALT     = 8'hA5;
    localparam logic [7:0] OP_RR          = 8'h03;
    localparam logic [7:0] OP_RRC         = 8'h13;
    localparam logic [7:0] OP_RL          = 8'h23;
    localparam logic [7:0] OP_RLC         = 8'h33;
    localparam logic [7:0] OP_SWAP        = 8'hC4;
    localparam logic [7:0] OP_CLR_A       = 8'hE4;
    localparam logic [7:0] OP_CPL_A       = 8'hF4;
    localparam logic [7:0] OP_MOV_A_DIR   = 8'hE5;
    localparam logic [7:0] OP_MOV_A_IMM   = 8'h74;
    localparam logic [7:0] OP_MOV_DIR_A   = 8'hF5;
    localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;

    typedef enum logic [2:0] {CL_NOP, CL_ARITH, CL_LOGIC, CL_ACC, CL_MOVE, CL_XDM, CL_UNSUP} mal_cls_e;
    typedef enum logic [3:0] {MD_NONE, MD_ACC, MD_REG, MD_DIR, MD_IND, MD_IMM, MD_DIR_A, MD_DIR_IMM,
                              MD_DIR_DIR, MD_DIR_IND, MD_DIR_REG, MD_REG_DIR, MD_XDM} mal_mode_e;
    typedef enum logic [1:0] {TG_ONCHIP, TG_OFFCHIP, TG_FLASH} mal_tgt_e;
    typedef enum logic {ST_OPC, ST_BODY} mal_state_e;

    typedef struct packed {
        mal_cls_e  cls;
        mal_mode_e mode;
    } mal_op_s;

    typedef struct packed {
        logic [1:0] len;
        logic [1:0] cyc;
    } mal_time_s;

    typedef struct packed {
        logic [7:0] opcode;
        mal_cls_e   cls;
        mal_mode_e  mode;
        logic [1:0] len;
        logic [1:0] cyc;
        logic [7:0] op1;
        logic [7:0] op2;
        logic       op1_special;
        logic       op2_special;
        logic [4:0] reg_addr;
        logic [7:0] ind_addr;
    } mal_dec_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        mal_tgt_e   target;
        logic [15:0] addr;
    } mal_xdm_s;

    function automatic mal_time_s mode_time(input mal_mode_e m);
        case (m)
            MD_DIR, MD_IMM, MD_DIR_A, MD_DIR_IND, MD_DIR_REG, MD_REG_DIR: return '{N_TWO, N_TWO};
            MD_IND: return '{N_ONE, N_TWO};
            MD_DIR_IMM, MD_DIR_DIR: return '{N_THREE, N_THREE};
            MD_XDM: return '{N_ONE, N_THREE};
            default: return '{N_ONE, N_ONE};
        endcase
    endfunction
endpackage

// ---- logic/mal_breg_mem.sv ----
// bank register storage, four banks of eight bytes, registered read
`timescale 1ns/1ps
module mal_breg_mem (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [4:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic       re,
    input  wire logic [4:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:31];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ---- tb/mal_prog_mem.sv ----
// partner model: program memory answering fetches in the same cycle
`timescale 1ns/1ps
module mal_prog_mem (
    input  wire logic [15:0] code_addr,
    output logic      [7:0]  code_byte
);
    logic [7:0] mem [0:255];
    // unwritten space reads as no-operation code
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end
    assign code_byte = mem[code_addr[7:0]];
endmodule

// ---- tb/mcu_alu_move_instr_timing_test.sv ----
// self-checking bench for the instruction decode and timing sequencer
`timescale 1ns/1ps
module mcu_alu_move_instr_timing_test;
    import mal_pkg::*;
    localparam int LIMIT = 5000;
    logic        clock;
    logic        nrst;
    logic [7:0]  code_byte;
    logic [1:0]  bank_sel;
    logic [15:0] data_pointer_pair;
    logic [7:0]  xdm_page;
    logic        flash_access_en;
    logic        breg_we;
    logic [4:0]  breg_waddr;
    logic [7:0]  breg_wdata;
    logic [15:0] code_addr;
    logic        instr_done;
    mal_dec_s    instr;
    mal_xdm_s    xdm;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    mal_core DUT (
        .clock             (clock),
        .nrst              (nrst),
        .code_byte         (code_byte),
        .bank_sel          (bank_sel),
        .data_pointer_pair (data_pointer_pair),
        .xdm_page          (xdm_page),
        .flash_access_en   (flash_access_en),
        .breg_we           (breg_we),
        .breg_waddr        (breg_waddr),
        .breg_wdata        (breg_wdata),
        .code_addr         (code_addr),
        .instr_done        (instr_done),
        .instr             (instr),
        .xdm               (xdm)
    );
    mal_prog_mem u_mem (
        .code_addr (code_addr),
        .code_byte (code_byte)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles >= LIMIT) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // load a program of like instructions behind two no-ops, reset, then judge each retirement
    task automatic run_grp(input logic [7:0] ops[$], input logic [1:0] len, input logic [1:0] cyc,
                           input mal_cls_e cls);
        int st[$];
        int pc;
        int last;
        int w;
        int s;
        @(posedge clock);
        nrst <= 1'b0;
        pc = 2;
        for (int a = 0; a < 256; a++) begin
            u_mem.mem[a] = 8'h00;
        end
        foreach (ops[i]) begin
            st.push_back(pc);
            u_mem.mem[pc] = ops[i];
            for (int k = 1; k < len; k++) begin
                u_mem.mem[pc + k] = 8'h7C + 8'(pc + k);
            end
            pc = pc + len;
        end
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        last = 0;
        for (int n = 0; n < ops.size() + 2; n++) begin
            w = 0;
            do begin
                @(negedge clock);
                w++;
            end while (instr_done !== 1'b1 && w < 12);
            check(instr_done, 1'b1, "completion");
            if (n >= 2) begin
                s = st[n - 2];
                check(instr.opcode, ops[n - 2], "opcode");
                check(instr.len, len, "length");
                check(instr.cyc, cyc, "cycle count");
                check(instr.cls, cls, "class");
                check(cycles - last, cyc, "spacing");
                check(code_addr, s + len, "fetch address");
                check(xdm.valid, cls == CL_XDM, "move strobe");
                if (len >= N_TWO) begin
                    check(instr.op1, u_mem.mem[s + 1], "first operand");
                    check(instr.op1_special, u_mem.mem[s + 1] >= SPECIAL_BASE, "first space");
                end
                if (len == N_THREE) begin
                    check(instr.op2, u_mem.mem[s + 2], "second operand");
                    check(instr.op2_special, u_mem.mem[s + 2] >= SPECIAL_BASE, "second space");
                end
            end
            last = cycles;
        end
    endtask

    task automatic t_arith();
        run_grp({8'h28, 8'h3F, 8'h9B}, N_ONE, N_ONE, CL_ARITH);
        run_grp({8'h25, 8'h35, 8'h95}, N_TWO, N_TWO, CL_ARITH);
        run_grp({8'h26, 8'h37, 8'h96}, N_ONE, N_TWO, CL_ARITH);
        run_grp({8'h24, 8'h34, 8'h94}, N_TWO, N_TWO, CL_ARITH);
        $display("test arith done");
    endtask

    task automatic t_logic();
        run_grp({8'h58, 8'h4F, 8'h6C}, N_ONE, N_ONE, CL_LOGIC);
        run_grp({8'h55, 8'h45, 8'h65}, N_TWO, N_TWO, CL_LOGIC);
        run_grp({8'h56, 8'h47, 8'h66}, N_ONE, N_TWO, CL_LOGIC);
        run_grp({8'h54, 8'h44, 8'h64}, N_TWO, N_TWO, CL_LOGIC);
        run_grp({8'h52, 8'h42, 8'h62}, N_TWO, N_TWO, CL_LOGIC);
        run_grp({8'h53, 8'h43, 8'h63}, N_THREE, N_THREE, CL_LOGIC);
        $display("test logic done");
    endtask

    task automatic t_move();
        run_grp({8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4}, N_ONE, N_ONE, CL_ACC);
        run_grp({8'hE5}, N_TWO, N_TWO, CL_MOVE);
        run_grp({8'hE6, 8'hE7}, N_ONE, N_TWO, CL_MOVE);
        run_grp({8'h78, 8'h7F, 8'h74}, N_TWO, N_TWO, CL_MOVE);
        run_grp({8'hA8, 8'hAF}, N_TWO, N_TWO, CL_MOVE);
        run_grp({8'h85, 8'h85}, N_THREE, N_THREE, CL_MOVE);
        run_grp({8'h88, 8'h8F}, N_TWO, N_TWO, CL_MOVE);
        run_grp({8'h86, 8'h87}, N_TWO, N_TWO, CL_MOVE);
        run_grp({8'hF5}, N_TWO, N_TWO, CL_MOVE);
        $display("test move done");
    endtask

    task automatic t_xdm();
        @(posedge clock);
        data_pointer_pair <= 16'h0FFF;
        run_grp({8'hE0}, N_ONE, N_THREE, CL_XDM);
        check(xdm.write, 1'b0, "direction");
        check(xdm.target, TG_ONCHIP, "target");
        check(xdm.addr, 16'h0FFF, "address");
        @(posedge clock);
        data_pointer_pair <= 16'h1000;
        run_grp({8'hF0}, N_ONE, N_THREE, CL_XDM);
        check(xdm.write, 1'b1, "direction");
        check(xdm.target, TG_OFFCHIP, "target");
        @(posedge clock);
        flash_access_en <= 1'b1;
        run_grp({8'hF0}, N_ONE, N_THREE, CL_XDM);
        check(xdm.target, TG_FLASH, "target");
        check(xdm.addr, 16'h1000, "address");
        @(posedge clock);
        flash_access_en <= 1'b0;
        bank_sel <= 2'h1;
        xdm_page <= 8'h3C;
        breg_we <= 1'b1;
        breg_waddr <= 5'h09;
        breg_wdata <= 8'h5A;
        @(posedge clock);
        breg_we <= 1'b0;
        run_grp({8'hE3}, N_ONE, N_THREE, CL_XDM);
        check(xdm.addr, 16'h3C5A, "pointer address");
        check(instr.ind_addr, 8'h5A, "pointer value");
        check(instr.reg_addr, 5'h09, "pointer register");
        $display("test external move done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        bank_sel = 2'h0;
        data_pointer_pair = 16'h0000;
        xdm_page = 8'h00;
        flash_access_en = 1'b0;
        breg_we = 1'b0;
        breg_waddr = 5'h00;
        breg_wdata = 8'h00;
        t_arith();
        t_logic();
        t_move();
        t_xdm();
        tally_and_finish();
    end
endmodule
